// file: rtl/tpg_defs.vh
/*
 Constants of the test packet generator: register offsets, control
 field positions, reset values, frame and gap sizes, CRC constants.
 Assumes inclusion by bare name from the design files under rtl/.
*/
`ifndef TPG_DEFS_VH
`define TPG_DEFS_VH

// ****************************************
// Register map
// ****************************************
`define TPG_ADDR_CTL 5'h1d
`define TPG_ADDR_PAT 5'h1e
`define TPG_CTL_RST 16'h0040
`define TPG_PAT_RST 16'h0000

// ****************************************
// Control fields
// ****************************************
`define TPG_EN_BIT 15
`define TPG_RUN_BIT 14
`define TPG_CONT_BIT 13
`define TPG_LEN_HI 12
`define TPG_LEN_LO 11
`define TPG_IPG_BIT 10
`define TPG_DST_HI 9
`define TPG_DST_LO 6
`define TPG_SRC_HI 5
`define TPG_SRC_LO 2
`define TPG_RAND_BIT 1
`define TPG_BADFCS_BIT 0

// ****************************************
// Frame sizes in bytes, gaps in bit times
// ****************************************
`define TPG_LEN_SEL_125 2'h0
`define TPG_LEN_SEL_64 2'h1
`define TPG_LEN_SEL_1518 2'h2
`define TPG_LEN_125 14'd125
`define TPG_LEN_64 14'd64
`define TPG_LEN_1518 14'd1518
`define TPG_LEN_10000 14'd10000
`define TPG_FCS_BYTES 14'd4
`define TPG_ADDR_BYTES 14'd6
`define TPG_HDR_BYTES 14'd12
`define TPG_GAP_BITS_SHORT 14'd96
`define TPG_GAP_BITS_LONG 14'd8192
`define TPG_BITS_PER_BYTE 14'd8
`define TPG_PRE_LAST 14'd7
`define TPG_FCS_LAST 14'd3
`define TPG_PRE_BYTE 8'h55
`define TPG_SFD_BYTE 8'hd5
`define TPG_ONES_BYTE 8'hff
`define TPG_ONES_NIB 4'hf

// ****************************************
// Run counts, CRC and payload generator
// ****************************************
`define TPG_BURST_PKTS 25'd30000000
`define TPG_BLOCK_PKTS 14'd10000
`define TPG_CRC_INIT 32'hffffffff
`define TPG_CRC_POLY 32'hedb88320
`define TPG_LFSR_SEED 16'hace1

`endif

// file: rtl/tpg_crc32.v
/*
 Byte-wide Ethernet CRC-32 accumulator, reflected form, one byte per
 enabled cycle. Assumes the caller inverts the result for the FCS.
*/
`timescale 1ns/10ps
`include "tpg_defs.vh"

module tpg_crc32 (
  input wire clk,
  input wire reset,
  input wire init,
  input wire en,
  input wire [7:0] din,
  output reg [31:0] crc
);

  // ****************************************
  // One byte of the CRC division
  // ****************************************
  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0] d;
    integer i;
    reg [31:0] r;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (r[0] ^ d[i]) begin
          r = (r >> 1) ^ `TPG_CRC_POLY;
        end else begin
          r = r >> 1;
        end
      end
      crc_byte = r;
    end
  endfunction

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      crc <= `TPG_CRC_INIT;
    end else if (init) begin
      crc <= `TPG_CRC_INIT;
    end else if (en) begin
      crc <= crc_byte(crc, din);
    end
  end

endmodule

// file: rtl/tpg_generator.v
/*
 Test packet generator of one PHY port: two management registers,
 frame sequencer, payload source and the transmit path multiplexer.
 Assumes one byte per clock toward the copper transmit path and a
 register port and MAC byte stream on the same clock as the block.
*/
// Operation
// - Bit 15 enables, bit 14 runs/stops
// - Duration bit 1: continuous, 10,000-packet blocks
// - Continuous cleared: stop at next 10,000 mark
// - Duration bit 0: exactly 30,000,000 packets, stop
// - Length field and gap bit select sizes
// - Destination all ones, low nibble bits 9:6
// - Source all ones, low nibble bits 5:2
// - Payload random or repeated fixed pattern
// - Bit 0 forces a bad FCS
// - Second register holds 16-bit payload pattern
// - Config changes apply only after run restart, except clearing bit 13 (continuous)
// - Pattern changes apply only after run restart
`timescale 1ns/10ps
`include "tpg_defs.vh"

module tpg_generator #(
  parameter [24:0] BURST_PKTS = `TPG_BURST_PKTS,
  parameter [13:0] BLOCK_PKTS = `TPG_BLOCK_PKTS
) (
  input wire clk,
  input wire reset,
  input wire [4:0] reg_addr,
  input wire reg_wr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  input wire [7:0] mac_txd,
  input wire mac_tx_en,
  input wire mac_tx_er,
  output reg [7:0] phy_txd,
  output reg phy_tx_en,
  output reg phy_tx_er,
  output wire gen_busy
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_PRE = 5'h02;
  localparam [4:0] ST_DATA = 5'h04;
  localparam [4:0] ST_FCS = 5'h08;
  localparam [4:0] ST_GAP = 5'h10;

  // ****************************************
  // Registers and run state
  // ****************************************
  reg [15:0] ctl;
  reg [15:0] pat;
  reg go_q;
  reg armed;
  reg restart;
  reg [4:0] state;
  reg [13:0] idx;
  reg [24:0] total_cnt;
  reg [13:0] blk_cnt;
  reg [15:0] lfsr;
  reg snap_cont;
  reg [1:0] snap_len;
  reg snap_ipg;
  reg [3:0] snap_dst;
  reg [3:0] snap_src;
  reg snap_rand;
  reg snap_bad;
  reg [15:0] snap_pat;
  reg [13:0] frame_len;
  reg [13:0] gap_len;
  reg [7:0] gen_byte;
  reg [7:0] next_txd;
  reg next_en;
  wire go;
  wire [31:0] crc;
  wire [31:0] fcs;
  wire [13:0] data_last;

  assign go = ctl[`TPG_EN_BIT] & ctl[`TPG_RUN_BIT];
  assign gen_busy = armed | (state != ST_IDLE);

  // ****************************************
  // Frame length and gap decode
  // ****************************************
  always @* begin
    case (snap_len)
      `TPG_LEN_SEL_125: frame_len = `TPG_LEN_125;
      `TPG_LEN_SEL_64: frame_len = `TPG_LEN_64;
      `TPG_LEN_SEL_1518: frame_len = `TPG_LEN_1518;
      default: frame_len = `TPG_LEN_10000;
    endcase
    if (snap_ipg) begin
      gap_len = `TPG_GAP_BITS_LONG / `TPG_BITS_PER_BYTE;
    end else begin
      gap_len = `TPG_GAP_BITS_SHORT / `TPG_BITS_PER_BYTE;
    end
  end

  assign data_last = frame_len - `TPG_FCS_BYTES - 14'd1;

  // ****************************************
  // Byte of the frame body at index idx
  // ****************************************
  always @* begin
    if (idx < `TPG_ADDR_BYTES) begin
      if (idx == `TPG_ADDR_BYTES - 14'd1) begin
        gen_byte = {`TPG_ONES_NIB, snap_dst};
      end else begin
        gen_byte = `TPG_ONES_BYTE;
      end
    end else if (idx < `TPG_HDR_BYTES) begin
      if (idx == `TPG_HDR_BYTES - 14'd1) begin
        gen_byte = {`TPG_ONES_NIB, snap_src};
      end else begin
        gen_byte = `TPG_ONES_BYTE;
      end
    end else if (snap_rand) begin
      gen_byte = lfsr[7:0];
    end else if (idx[0] == 1'b0) begin
      gen_byte = snap_pat[15:8];
    end else begin
      gen_byte = snap_pat[7:0];
    end
  end

  // Good FCS is the inverted CRC; a bad one sends it uninverted
  assign fcs = ~crc ^ {32{snap_bad}};

  // ****************************************
  // Generator byte toward the transmit path
  // ****************************************
  always @* begin
    next_txd = 8'h00;
    next_en = 1'b0;
    case (state)
      ST_PRE: begin
        next_en = 1'b1;
        next_txd = (idx == `TPG_PRE_LAST) ? `TPG_SFD_BYTE : `TPG_PRE_BYTE;
      end
      ST_DATA: begin
        next_en = 1'b1;
        next_txd = gen_byte;
      end
      ST_FCS: begin
        next_en = 1'b1;
        case (idx[1:0])
          2'h0: next_txd = fcs[7:0];
          2'h1: next_txd = fcs[15:8];
          2'h2: next_txd = fcs[23:16];
          default: next_txd = fcs[31:24];
        endcase
      end
      default: begin
        next_en = 1'b0;
        next_txd = 8'h00;
      end
    endcase
  end

  tpg_crc32 u_crc (
    .clk(clk),
    .reset(reset),
    .init(state == ST_PRE),
    .en(state == ST_DATA),
    .din(gen_byte),
    .crc(crc)
  );

  // ****************************************
  // Registers, sequencer and counters
  // ****************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl <= `TPG_CTL_RST;
      pat <= `TPG_PAT_RST;
      reg_rdata <= 16'h0000;
      go_q <= 1'b0;
      armed <= 1'b0;
      restart <= 1'b0;
      state <= ST_IDLE;
      idx <= 14'd0;
      total_cnt <= 25'd0;
      blk_cnt <= 14'd0;
      lfsr <= `TPG_LFSR_SEED;
      snap_cont <= 1'b0;
      snap_len <= 2'h0;
      snap_ipg <= 1'b0;
      snap_dst <= 4'h0;
      snap_src <= 4'h0;
      snap_rand <= 1'b0;
      snap_bad <= 1'b0;
      snap_pat <= 16'h0000;
      phy_txd <= 8'h00;
      phy_tx_en <= 1'b0;
      phy_tx_er <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `TPG_ADDR_CTL) begin
        ctl <= reg_wdata;
      end
      if (reg_wr && reg_addr == `TPG_ADDR_PAT) begin
        pat <= reg_wdata;
      end
      case (reg_addr)
        `TPG_ADDR_CTL: reg_rdata <= ctl;
        `TPG_ADDR_PAT: reg_rdata <= pat;
        default: reg_rdata <= 16'h0000;
      endcase
      go_q <= go;
      if (!go) begin
        armed <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          idx <= 14'd0;
          if (armed && go) begin
            state <= ST_PRE;
            if (restart) begin
              // Settings are sampled only at the start of a run
              restart <= 1'b0;
              total_cnt <= 25'd0;
              blk_cnt <= 14'd0;
              lfsr <= `TPG_LFSR_SEED;
              snap_cont <= ctl[`TPG_CONT_BIT];
              snap_len <= ctl[`TPG_LEN_HI:`TPG_LEN_LO];
              snap_ipg <= ctl[`TPG_IPG_BIT];
              snap_dst <= ctl[`TPG_DST_HI:`TPG_DST_LO];
              snap_src <= ctl[`TPG_SRC_HI:`TPG_SRC_LO];
              snap_rand <= ctl[`TPG_RAND_BIT];
              snap_bad <= ctl[`TPG_BADFCS_BIT];
              snap_pat <= pat;
            end
          end
        end
        ST_PRE: begin
          if (idx == `TPG_PRE_LAST) begin
            idx <= 14'd0;
            state <= ST_DATA;
          end else begin
            idx <= idx + 14'd1;
          end
        end
        ST_DATA: begin
          if (idx >= `TPG_HDR_BYTES) begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
          end
          if (idx == data_last) begin
            idx <= 14'd0;
            state <= ST_FCS;
          end else begin
            idx <= idx + 14'd1;
          end
        end
        ST_FCS: begin
          if (idx == `TPG_FCS_LAST) begin
            idx <= 14'd0;
            state <= ST_GAP;
            total_cnt <= total_cnt + 25'd1;
            if (blk_cnt == BLOCK_PKTS - 14'd1) begin
              blk_cnt <= 14'd0;
            end else begin
              blk_cnt <= blk_cnt + 14'd1;
            end
            if (snap_cont) begin
              if (blk_cnt == BLOCK_PKTS - 14'd1 && !ctl[`TPG_CONT_BIT]) begin
                armed <= 1'b0;
              end
            end else if (total_cnt == BURST_PKTS - 25'd1) begin
              armed <= 1'b0;
            end
          end else begin
            idx <= idx + 14'd1;
          end
        end
        ST_GAP: begin
          // The idle cycle before the next preamble counts toward the gap
          if (idx >= gap_len - 14'd2) begin
            idx <= 14'd0;
            state <= ST_IDLE;
          end else begin
            idx <= idx + 14'd1;
          end
        end
        default: begin
          idx <= 14'd0;
          state <= ST_IDLE;
        end
      endcase
      // A fresh start wins over any stop taken in the same cycle
      if (go && !go_q) begin
        armed <= 1'b1;
        restart <= 1'b1;
      end
      // While enabled the generator owns the transmit path
      if (ctl[`TPG_EN_BIT]) begin
        phy_txd <= next_txd;
        phy_tx_en <= next_en;
        phy_tx_er <= 1'b0;
      end else begin
        phy_txd <= mac_txd;
        phy_tx_en <= mac_tx_en;
        phy_tx_er <= mac_tx_er;
      end
    end
  end

endmodule

// file: test/tpg_checker_checker.sv
/*
 Port checker of the test packet generator, bound into tpg_generator.
 Assumes it sees only the generator's ports and tpg_defs.vh constants.
*/
`timescale 1ns/10ps
`include "tpg_defs.vh"
module tpg_checker #(
  parameter [24:0] BURST_PKTS = `TPG_BURST_PKTS,
  parameter [13:0] BLOCK_PKTS = `TPG_BLOCK_PKTS
) (
  input wire clk,
  input wire reset,
  input wire [4:0] reg_addr,
  input wire reg_wr,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire [7:0] mac_txd,
  input wire mac_tx_en,
  input wire mac_tx_er,
  input wire [7:0] phy_txd,
  input wire phy_tx_en,
  input wire phy_tx_er,
  input wire gen_busy
);
  reg [15:0] ctl;
  reg [15:0] pat;
  wire en = ctl[`TPG_EN_BIT];
  wire go = en & ctl[`TPG_RUN_BIT];
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Shadow of both registers from observed writes
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl <= `TPG_CTL_RST;
      pat <= `TPG_PAT_RST;
    end else if (reg_wr && reg_addr == `TPG_ADDR_CTL) begin
      ctl <= reg_wdata;
    end else if (reg_wr && reg_addr == `TPG_ADDR_PAT) begin
      pat <= reg_wdata;
    end
  end
  // ****
  // Assertions
  // ****
  AST_RD_CTL: assert property (reg_addr == `TPG_ADDR_CTL |=> reg_rdata == $past(ctl))
    else $error("control read mismatch");
  AST_RD_PAT: assert property (reg_addr == `TPG_ADDR_PAT |=> reg_rdata == $past(pat))
    else $error("pattern read mismatch");
  AST_RD_NONE: assert property (reg_addr != `TPG_ADDR_CTL &&
    reg_addr != `TPG_ADDR_PAT |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_PASS: assert property (!en |=> phy_txd == $past(mac_txd) &&
    phy_tx_en == $past(mac_tx_en) && phy_tx_er == $past(mac_tx_er))
    else $error("MAC stream not passed");
  AST_OWN_ER: assert property (en |=> !phy_tx_er)
    else $error("error flag while generating");
  AST_START: assert property ($rose(go) && !gen_busy |-> ##[1:4] phy_tx_en)
    else $error("run did not start");
  AST_PREAMBLE: assert property ($past(en) && $past(en, 2) && $rose(phy_tx_en)
    |-> phy_txd == `TPG_PRE_BYTE [*7] ##1 phy_txd == `TPG_SFD_BYTE)
    else $error("bad preamble");
  AST_GAP: assert property ($past(en) && $fell(phy_tx_en) |-> !phy_tx_en [*8])
    else $error("gap too short");
endmodule
bind tpg_generator tpg_checker #(.BURST_PKTS(BURST_PKTS), .BLOCK_PKTS(BLOCK_PKTS)) CHK (
  .clk, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .mac_txd, .mac_tx_en,
  .mac_tx_er, .phy_txd, .phy_tx_en, .phy_tx_er, .gen_busy);

// file: test/tpg_link_model.sv
/*
 Receiving end of the copper transmit path: captures frames and gaps.
 Assumes one byte per clock with 8 preamble bytes ahead of each frame.
*/
`timescale 1ns/10ps
module tpg_link_model (
  input wire clk,
  input wire reset,
  input wire [7:0] phy_txd,
  input wire phy_tx_en,
  output int frames,
  output int flen,
  output int gap
);
  logic [7:0] rx [0:10015];
  int cnt;
  int idle;
  // Isolated test link, never a live network
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      frames <= 0;
      flen <= 0;
      gap <= 0;
      cnt <= 0;
      idle <= 0;
    end else if (phy_tx_en) begin
      if (cnt >= 8) rx[cnt-8] <= phy_txd;
      if (idle > 0) gap <= idle;
      cnt <= cnt + 1;
      idle <= 0;
    end else begin
      if (cnt > 0) frames <= frames + 1;
      if (cnt > 0) flen <= cnt - 8;
      cnt <= 0;
      idle <= idle + 1;
    end
  end
endmodule

// file: test/ethernet_test_packet_generator_bench.sv
/*
 Self-checking bench of the test packet generator with a link model.
 Assumes the checker is bound in and tpg_defs.vh is on the path.
*/
`timescale 1ns/10ps
`include "tpg_defs.vh"
module ethernet_test_packet_generator_bench;
  localparam [24:0] BP = 25'd3;
  localparam [13:0] BK = 14'd2;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic reg_wr = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [7:0] mac_txd = 8'h00;
  logic mac_tx_en = 1'b0;
  logic mac_tx_er = 1'b0;
  wire [15:0] reg_rdata;
  wire [7:0] phy_txd;
  wire phy_tx_en;
  wire phy_tx_er;
  wire gen_busy;
  int frames;
  int flen;
  int gap;
  int fail_count = 0;
  int samples_checked = 0;
  tpg_generator #(.BURST_PKTS(BP), .BLOCK_PKTS(BK)) DUT (.clk, .reset, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rdata, .mac_txd, .mac_tx_en, .mac_tx_er, .phy_txd, .phy_tx_en,
    .phy_tx_er, .gen_busy);
  tpg_link_model LINK (.clk, .reset, .phy_txd, .phy_tx_en, .frames, .flen, .gap);
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    #1;
    mac_txd <= $urandom;
    mac_tx_en <= $urandom;
    mac_tx_er <= $urandom;
  end
  task test_done;
    if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [4:0] a, input [15:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wr = 1'b1;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask
  task rd(input [4:0] a, output [15:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask
  task wait_tx;
    int k;
    for (k = 0; k < 100 && phy_tx_en !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task wait_idle;
    int k;
    for (k = 0; k < 60000 && gen_busy !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    chk(gen_busy, 0);
  endtask
  function [15:0] mk(input c, input [1:0] l, input g, input [3:0] d, input [3:0] s,
    input r, input b);
    return {2'b11, c, l, g, d, s, r, b};
  endfunction
  function int len_of(input [1:0] l);
    case (l)
      2'h0: return `TPG_LEN_125;
      2'h1: return `TPG_LEN_64;
      2'h2: return `TPG_LEN_1518;
      default: return `TPG_LEN_10000;
    endcase
  endfunction
  function [7:0] exp_byte(input int i, input [3:0] d, input [3:0] s, input [15:0] p);
    if (i < 5 || (i > 5 && i < 11)) return 8'hff;
    if (i == 5) return {4'hf, d};
    if (i == 11) return {4'hf, s};
    return (i % 2 == 0) ? p[15:8] : p[7:0];
  endfunction
  function [31:0] crc_of(input int n);
    logic [31:0] c;
    c = `TPG_CRC_INIT;
    for (int i = 0; i < n; i++) begin
      c = c ^ LINK.rx[i];
      for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ `TPG_CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  task chk_frame(input int n, input [3:0] d, input [3:0] s, input [15:0] p, input b,
    input fix);
    logic [31:0] c;
    chk(flen, n);
    for (int i = 0; i < n - 4; i++) begin
      if (fix || i < 12) chk(LINK.rx[i], exp_byte(i, d, s, p));
    end
    c = crc_of(n - 4) ^ (b ? 32'h00000000 : 32'hffffffff);
    chk({LINK.rx[n-1], LINK.rx[n-2], LINK.rx[n-3], LINK.rx[n-4]}, c);
  endtask
  initial begin
    #1000000;
    fail_count++;
    test_done;
  end
  // ****
  // Scenarios
  // ****
  initial begin
    logic [15:0] v;
    logic [15:0] v2;
    logic [15:0] x;
    logic [15:0] p;
    logic [3:0] d;
    logic [3:0] s;
    int f;
    void'($urandom(29614));
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    rd(`TPG_ADDR_CTL, x);
    chk(x, `TPG_CTL_RST);
    wr(5'h05, 16'hffff);
    rd(5'h05, x);
    chk(x, 0);
    rd(`TPG_ADDR_PAT, x);
    chk(x, `TPG_PAT_RST);
    wr(`TPG_ADDR_CTL, `TPG_CTL_RST | 16'h8000);
    repeat (4) @(posedge clk);
    #1;
    chk(phy_tx_en, 0);
    chk(gen_busy, 0);
    for (int l = 0; l < 4; l++) begin
      d = $urandom;
      s = $urandom;
      p = $urandom;
      f = frames;
      v = mk(1'b1, l[1:0], 1'b0, d, s, l == 3, l[0]);
      wr(`TPG_ADDR_PAT, p);
      wr(`TPG_ADDR_CTL, v);
      wait_tx;
      wr(`TPG_ADDR_CTL, v & 16'hbfff);
      wait_idle;
      chk(frames - f, 1);
      chk_frame(len_of(l[1:0]), d, s, p, l[0], l != 3);
    end
    d = $urandom;
    s = $urandom;
    p = $urandom;
    f = frames;
    v = mk(1'b0, `TPG_LEN_SEL_64, 1'b1, d, s, 1'b0, 1'b0);
    v2 = mk(1'b0, `TPG_LEN_SEL_125, 1'b0, ~d, s, 1'b0, 1'b0);
    wr(`TPG_ADDR_PAT, p);
    wr(`TPG_ADDR_CTL, v);
    wait_tx;
    wr(`TPG_ADDR_PAT, ~p);
    wr(`TPG_ADDR_CTL, v2);
    wait_idle;
    chk(frames - f, BP);
    chk_frame(`TPG_LEN_64, d, s, p, 1'b0, 1'b1);
    chk(gap, `TPG_GAP_BITS_LONG / `TPG_BITS_PER_BYTE);
    wr(`TPG_ADDR_CTL, v2 & 16'hbfff);
    f = frames;
    wr(`TPG_ADDR_CTL, v2 | 16'h2000);
    wait_tx;
    wr(`TPG_ADDR_CTL, v2);
    wait_idle;
    chk(frames - f, BK);
    chk_frame(`TPG_LEN_125, ~d, s, ~p, 1'b0, 1'b1);
    chk(gap, `TPG_GAP_BITS_SHORT / `TPG_BITS_PER_BYTE);
    wr(`TPG_ADDR_CTL, 16'h0000);
    rd(`TPG_ADDR_CTL, x);
    chk(x, 0);
    // Reset during the first preamble byte of a frame returns everything to defaults
    wr(`TPG_ADDR_CTL, mk(1'b1, `TPG_LEN_SEL_1518, 1'b0, d, s, 1'b1, 1'b0));
    wait_tx;
    reset = 1'b1;
    @(posedge clk);
    #1;
    chk(phy_tx_en, 0);
    chk(gen_busy, 0);
    @(posedge clk);
    #1;
    reset = 1'b0;
    rd(`TPG_ADDR_CTL, x);
    chk(x, `TPG_CTL_RST);
    rd(`TPG_ADDR_PAT, x);
    chk(x, `TPG_PAT_RST);
    repeat (20) @(posedge clk);
    test_done;
  end
endmodule
